// [rtl/rbl_loader.sv]
// rom boot image loader: header scan, checks, copy to memory
`timescale 1ns/1ps
// Function
// - search regions from lowest physical address upward.
// - regions are separate; gaps between them are never searched.
// - headers are looked for only on page boundaries.
// - keep scanning a region after a valid image.
// - low byte of header word 0 must be 80 hex.
// - upper half of word 0 must invert its lower half.
// - sum of words 0..4 modulo 2^64 must equal word 5.
// - each valid header raises a boot-type event with its label word.
// - before the ordinal, use length at +24 to find next page.
// - ordinal not found in any region aborts.
// - image start is header base plus offset word at +16.
// - probe every image page; abort if one fails, else event.
// - optional image sum versus word at +8; abort or verified event.
// - optional copy into ram from fixed base as one buffer.
// - load-begins before copy, load-done after clean copy.
module rbl_loader (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // request
    input wire logic start_i,
    input wire logic [7:0] ordinal_i,
    input wire logic validate_i,
    input wire logic copy_i,
    input wire logic audit_i,
    // rom region table, ascending, upper bound exclusive
    input wire logic [rbl_pkg::NREG-1:0][63:0] region_lo_i,
    input wire logic [rbl_pkg::NREG-1:0][63:0] region_hi_i,
    // rom read port
    output logic rom_req_o,
    output logic [63:0] rom_addr_o,
    input wire logic rom_ack_i,
    input wire logic rom_err_i,
    input wire logic [63:0] rom_data_i,
    // system memory write port
    output logic ram_valid_o,
    input wire logic ram_ready_i,
    output logic [63:0] ram_addr_o,
    output logic [63:0] ram_data_o,
    // events
    output logic evt_valid_o,
    output rbl_pkg::rbl_evt_t evt_code_o,
    output logic [63:0] loader_label_word_o,
    // result
    output logic abort_o,
    output rbl_pkg::rbl_abort_t abort_step_o,
    output logic ready_o,
    output logic [63:0] start_addr_o,
    input wire logic ack_i
);
    typedef struct packed {
        rbl_pkg::rbl_state_t st;
        logic [5:0][63:0] hdr;
        logic [63:0] header_base;
        logic [63:0] addr;
        logic [63:0] start;
        logic [63:0] lim;
        logic [63:0] sum;
        logic [63:0] raddr;
        logic [63:0] lbl;
        logic [1:0] rgn;
        logic [2:0] hidx;
        logic [7:0] ord;
        logic [7:0] found;
        logic val;
        logic cpy;
        logic aud;
        logic req;
        logic evt_v;
        rbl_pkg::rbl_evt_t evt_c;
        logic abrt;
        rbl_pkg::rbl_abort_t astep;
        logic rdy;
    } rbl_ld_s_t;

    rbl_ld_s_t q_reg, q_next;
    logic [63:0] hsum;
    logic [63:0] nxt;
    logic [63:0] w0;
    logic hdr_ok;
    logic push;
    logic f_ready;
    logic f_valid;

    // header checks on the stored words
    assign w0 = q_reg.hdr[0];
    assign hsum = q_reg.hdr[0] + q_reg.hdr[1] + q_reg.hdr[2] +
                  q_reg.hdr[3] + q_reg.hdr[4];
    assign hdr_ok = (w0[7:0] == rbl_pkg::HDR_MARK) &&
                    (w0[63:32] == ~w0[31:0]) &&
                    (hsum == q_reg.hdr[rbl_pkg::IDX_HSUM]);
    // next page after an image; a zero length still moves one page
    assign nxt = (q_reg.header_base + q_reg.hdr[rbl_pkg::IDX_LEN] +
                  rbl_pkg::PAGE_MASK) & ~rbl_pkg::PAGE_MASK;
    assign push = (q_reg.st == rbl_pkg::S_COPY) && q_reg.req &&
                  rom_ack_i && !rom_err_i;

    // sequencer
    always_comb begin
        q_next = q_reg;
        q_next.evt_v = 1'b0;
        unique case (q_reg.st)
            rbl_pkg::S_IDLE, rbl_pkg::S_ABORT: begin
                if (start_i) begin
                    q_next = '0;
                    q_next.st = rbl_pkg::S_SEEK;
                    q_next.ord = ordinal_i;
                    q_next.val = validate_i;
                    q_next.cpy = copy_i;
                    q_next.aud = audit_i;
                    // lowest region first, first page boundary in it
                    q_next.header_base = (region_lo_i[0] +
                        rbl_pkg::PAGE_MASK) & ~rbl_pkg::PAGE_MASK;
                end
            end
            rbl_pkg::S_SEEK: begin
                // header must fit inside the current region
                if (q_reg.header_base + rbl_pkg::HDR_SPAN >
                    region_hi_i[q_reg.rgn]) begin
                    if (q_reg.rgn == rbl_pkg::RGN_LAST) begin
                        q_next.st = rbl_pkg::S_ABORT;
                        q_next.abrt = 1'b1;
                        q_next.astep = rbl_pkg::AB_NOT_FOUND;
                    end else begin
                        q_next.rgn = q_reg.rgn + 2'h1;
                        q_next.header_base =
                            (region_lo_i[q_reg.rgn + 2'h1] +
                            rbl_pkg::PAGE_MASK) & ~rbl_pkg::PAGE_MASK;
                    end
                end else begin
                    q_next.st = rbl_pkg::S_HDR;
                    q_next.hidx = 3'h0;
                    q_next.addr = q_reg.header_base;
                end
            end
            rbl_pkg::S_HDR: begin
                if (!q_reg.req) q_next.req = 1'b1;
                else if (rom_ack_i) begin
                    q_next.req = 1'b0;
                    q_next.hdr[q_reg.hidx] = rom_data_i;
                    if (rom_err_i) begin
                        // unreadable page holds no header
                        q_next.header_base =
                            q_reg.header_base + rbl_pkg::PAGE_BYTES;
                        q_next.st = rbl_pkg::S_SEEK;
                    end else if (q_reg.hidx == rbl_pkg::HDR_LAST) begin
                        q_next.st = rbl_pkg::S_CHK;
                    end else begin
                        q_next.hidx = q_reg.hidx + 3'h1;
                        q_next.addr = q_reg.addr + rbl_pkg::WORD_BYTES;
                    end
                end
            end
            rbl_pkg::S_CHK: begin
                q_next.st = rbl_pkg::S_SEEK;
                if (!hdr_ok) begin
                    q_next.header_base =
                        q_reg.header_base + rbl_pkg::PAGE_BYTES;
                end else begin
                    q_next.evt_v = q_reg.aud;
                    q_next.evt_c = rbl_pkg::EVT_BOOT_TYPE;
                    q_next.lbl = q_reg.hdr[rbl_pkg::IDX_LABEL];
                    if (q_reg.found == q_reg.ord) begin
                        q_next.start = q_reg.header_base +
                            q_reg.hdr[rbl_pkg::IDX_OFFSET];
                        q_next.lim = q_reg.header_base +
                            q_reg.hdr[rbl_pkg::IDX_OFFSET] +
                            q_reg.hdr[rbl_pkg::IDX_LEN];
                        q_next.addr = q_reg.header_base +
                            q_reg.hdr[rbl_pkg::IDX_OFFSET];
                        q_next.st = rbl_pkg::S_PAGE;
                    end else begin
                        // stay in this region, skip past the image
                        q_next.found = q_reg.found + 8'h01;
                        q_next.header_base = (nxt == q_reg.header_base) ?
                            nxt + rbl_pkg::PAGE_BYTES : nxt;
                    end
                end
            end
            rbl_pkg::S_PAGE: begin
                if (q_reg.addr >= q_reg.lim) begin
                    q_next.evt_v = q_reg.aud;
                    q_next.evt_c = rbl_pkg::EVT_PAGES_REACHABLE;
                    q_next.addr = q_reg.start;
                    q_next.sum = '0;
                    q_next.st = q_reg.val ? rbl_pkg::S_SUM :
                                            rbl_pkg::S_COPY_GO;
                end else if (!q_reg.req) q_next.req = 1'b1;
                else if (rom_ack_i) begin
                    q_next.req = 1'b0;
                    if (rom_err_i) begin
                        q_next.st = rbl_pkg::S_ABORT;
                        q_next.abrt = 1'b1;
                        q_next.astep = rbl_pkg::AB_PAGE;
                    end else begin
                        // one probe per page is enough
                        q_next.addr = (q_reg.addr & ~rbl_pkg::PAGE_MASK) +
                                      rbl_pkg::PAGE_BYTES;
                    end
                end
            end
            rbl_pkg::S_SUM: begin
                if (q_reg.addr >= q_reg.lim) begin
                    if (q_reg.sum == q_reg.hdr[rbl_pkg::IDX_IMG_SUM]) begin
                        q_next.evt_v = q_reg.aud;
                        q_next.evt_c = rbl_pkg::EVT_PAYLOAD_VERIFIED;
                        q_next.st = rbl_pkg::S_COPY_GO;
                    end else begin
                        q_next.st = rbl_pkg::S_ABORT;
                        q_next.abrt = 1'b1;
                        q_next.astep = rbl_pkg::AB_SUM;
                    end
                end else if (!q_reg.req) q_next.req = 1'b1;
                else if (rom_ack_i) begin
                    q_next.req = 1'b0;
                    q_next.sum = q_reg.sum + rom_data_i;
                    q_next.addr = q_reg.addr + rbl_pkg::WORD_BYTES;
                    if (rom_err_i) begin
                        q_next.st = rbl_pkg::S_ABORT;
                        q_next.abrt = 1'b1;
                        q_next.astep = rbl_pkg::AB_SUM;
                    end
                end
            end
            rbl_pkg::S_COPY_GO: begin
                q_next.addr = q_reg.start;
                q_next.raddr = rbl_pkg::RAM_BASE;
                if (q_reg.cpy) begin
                    q_next.evt_v = q_reg.aud;
                    q_next.evt_c = rbl_pkg::EVT_LOAD_BEGINS;
                    q_next.st = rbl_pkg::S_COPY;
                end else begin
                    q_next.st = rbl_pkg::S_DONE;
                    q_next.rdy = 1'b1;
                end
            end
            rbl_pkg::S_COPY: begin
                // reads only issue with room in the fifo
                if (q_reg.addr >= q_reg.lim && !q_reg.req) begin
                    if (!f_valid) begin
                        q_next.evt_v = q_reg.aud;
                        q_next.evt_c = rbl_pkg::EVT_LOAD_DONE;
                        q_next.st = rbl_pkg::S_DONE;
                        q_next.rdy = 1'b1;
                    end
                end else if (!q_reg.req) q_next.req = f_ready;
                else if (rom_ack_i) begin
                    q_next.req = 1'b0;
                    q_next.addr = q_reg.addr + rbl_pkg::WORD_BYTES;
                    if (rom_err_i) begin
                        q_next.st = rbl_pkg::S_ABORT;
                        q_next.abrt = 1'b1;
                        q_next.astep = rbl_pkg::AB_COPY;
                    end
                end
                if (ram_valid_o && ram_ready_i) begin
                    q_next.raddr = q_reg.raddr + rbl_pkg::WORD_BYTES;
                end
            end
            rbl_pkg::S_DONE: begin
                if (ack_i) begin
                    q_next.rdy = 1'b0;
                    q_next.st = rbl_pkg::S_IDLE;
                end
            end
            default: q_next.st = rbl_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) q_reg <= '0;
        else q_reg <= q_next;
    end

    // copy buffer; flushed on abort so ram writes stop
    rbl_fifo #(.W(rbl_pkg::WORD_W), .DEPTH(rbl_pkg::FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .clr_i(q_reg.abrt),
        .in_valid_i(push),
        .in_ready_o(f_ready),
        .in_data_i(rom_data_i),
        .out_valid_o(f_valid),
        .out_ready_i(ram_ready_i),
        .out_data_o(ram_data_o)
    );

    // outputs
    assign rom_req_o = q_reg.req;
    assign rom_addr_o = q_reg.addr;
    assign ram_valid_o = f_valid && !q_reg.abrt;
    assign ram_addr_o = q_reg.raddr;
    assign evt_valid_o = q_reg.evt_v;
    assign evt_code_o = q_reg.evt_c;
    assign loader_label_word_o = q_reg.lbl;
    assign abort_o = q_reg.abrt;
    assign abort_step_o = q_reg.astep;
    assign ready_o = q_reg.rdy;
    assign start_addr_o = q_reg.start;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence seq_boot_evt;
        evt_valid_o && evt_code_o == rbl_pkg::EVT_BOOT_TYPE;
    endsequence
    sequence seq_load_begin;
        evt_valid_o && evt_code_o == rbl_pkg::EVT_LOAD_BEGINS;
    endsequence
    sequence seq_load_done;
        evt_valid_o && evt_code_o == rbl_pkg::EVT_LOAD_DONE;
    endsequence

    a_marker_byte: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        seq_boot_evt |-> q_reg.hdr[0][7:0] == 8'h80)
        else $error("boot event without header marker");
    a_complement_check: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        seq_boot_evt |-> q_reg.hdr[0][63:32] == ~q_reg.hdr[0][31:0])
        else $error("boot event with bad complement");
    a_header_sum: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        seq_boot_evt |-> loader_label_word_o == q_reg.hdr[4] &&
        hsum == q_reg.hdr[5])
        else $error("boot event with bad header sum");
    a_events_audited: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        evt_valid_o |-> q_reg.aud)
        else $error("event raised with audit off");
    a_start_address: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        ready_o |-> start_addr_o == q_reg.header_base + q_reg.hdr[2])
        else $error("start address not base plus offset");
    a_copy_base: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        seq_load_begin |-> ram_addr_o == 64'h0000_0000_2000_0000 &&
        !ram_valid_o)
        else $error("copy not starting at buffer base");
    a_load_done_clean: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        seq_load_done |-> !abort_o && !ram_valid_o ##1 ready_o)
        else $error("load done before copy finished");
    a_abort_quiet: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        abort_o && !start_i |=> abort_o && !rom_req_o && !ram_valid_o &&
        abort_step_o != rbl_pkg::AB_NONE)
        else $error("access after abort");
    a_ready_holds: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        ready_o && !ack_i |=> ready_o && $stable(start_addr_o))
        else $error("ready dropped without acknowledge");
    a_rom_req_hold: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        rom_req_o && !rom_ack_i |=> rom_req_o && $stable(rom_addr_o))
        else $error("rom request withdrawn early");
endmodule

// [shared/rbl_pkg.sv]
// constants and types shared by the rom boot image loader
package rbl_pkg;
    localparam int NREG = 4;
    localparam logic [1:0] RGN_LAST = 2'h3;
    localparam int FIFO_DEPTH = 32;
    localparam int WORD_W = 64;
    // page geometry; page size is a plain default
    localparam logic [63:0] PAGE_BYTES = 64'h0000_0000_0000_2000;
    localparam logic [63:0] PAGE_MASK = 64'h0000_0000_0000_1fff;
    localparam logic [63:0] WORD_BYTES = 64'h0000_0000_0000_0008;
    // header layout: six words, span of the checked part
    localparam logic [63:0] HDR_SPAN = 64'h0000_0000_0000_0030;
    localparam logic [2:0] HDR_LAST = 3'h5;
    localparam logic [7:0] HDR_MARK = 8'h80;
    localparam int IDX_IMG_SUM = 1;
    localparam int IDX_OFFSET = 2;
    localparam int IDX_LEN = 3;
    localparam int IDX_LABEL = 4;
    localparam int IDX_HSUM = 5;
    // fixed base of the copy buffer in system memory
    localparam logic [63:0] RAM_BASE = 64'h0000_0000_2000_0000;
    typedef enum logic [2:0] {
        EVT_BOOT_TYPE, EVT_PAGES_REACHABLE, EVT_PAYLOAD_VERIFIED,
        EVT_LOAD_BEGINS, EVT_LOAD_DONE
    } rbl_evt_t;
    typedef enum logic [2:0] {
        AB_NONE, AB_NOT_FOUND, AB_PAGE, AB_SUM, AB_COPY
    } rbl_abort_t;
    typedef enum logic [3:0] {
        S_IDLE, S_SEEK, S_HDR, S_CHK, S_PAGE, S_SUM, S_COPY_GO,
        S_COPY, S_DONE, S_ABORT
    } rbl_state_t;
endpackage

// [rtl/rbl_fifo.sv]
// word fifo between rom reads and system memory writes
`timescale 1ns/1ps
module rbl_fifo #(
    parameter int W = 64,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic clr_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } rbl_fifo_s_t;
    rbl_fifo_s_t q_reg, q_next;
    logic [W-1:0] mem [DEPTH];
    logic full, empty;

    // extra pointer bit tells full from empty
    assign empty = q_reg.wr == q_reg.rd;
    assign full = (q_reg.wr[AW] != q_reg.rd[AW]) &&
                  (q_reg.wr[AW-1:0] == q_reg.rd[AW-1:0]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[q_reg.rd[AW-1:0]];

    // pointer update
    always_comb begin
        q_next = q_reg;
        if (in_valid_i && !full) q_next.wr = q_reg.wr + 1'b1;
        if (out_ready_i && !empty) q_next.rd = q_reg.rd + 1'b1;
        if (clr_i) q_next = '0;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) q_reg <= '0;
        else q_reg <= q_next;
        if (in_valid_i && !full) mem[q_reg.wr[AW-1:0]] <= in_data_i;
    end
endmodule

// [testbench/rbl_mem_model.sv]
// behavioural boot rom regions and system memory sink for the loader
`timescale 1ns/1ps
module rbl_mem_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // rom read port
    input wire logic rom_req_i,
    input wire logic [63:0] rom_addr_i,
    output logic rom_ack_o,
    output logic rom_err_o,
    output logic [63:0] rom_data_o,
    // system memory write port
    input wire logic ram_valid_i,
    output logic ram_ready_o,
    input wire logic [63:0] ram_addr_i,
    input wire logic [63:0] ram_data_i,
    // bench controls
    input wire logic [1:0] rom_lat_i,
    input wire logic ram_en_i
);
    // ------------------------------------------------------------
    // storage, filled and read back by the bench
    // ------------------------------------------------------------
    logic [63:0] rom [logic [63:0]];
    logic [63:0] ram [$];
    logic [63:0] bad_lo = 64'h0;
    logic [63:0] bad_hi = 64'h0;
    logic ram_bad = 1'b0;
    logic [1:0] wait_q;
    logic [63:0] last_q;
    logic ph_q;
    logic hit;

    // answer after a chosen wait; outside an answer the data lines show
    // the inverse of the last word, so a stale sample never matches
    always_comb begin
        hit = rom_req_i && (wait_q == rom_lat_i);
        rom_ack_o = hit;
        rom_err_o = hit && rom_addr_i >= bad_lo && rom_addr_i < bad_hi;
        rom_data_o = ~last_q;
        if (hit && rom.exists(rom_addr_i)) begin
            rom_data_o = rom[rom_addr_i];
        end else if (hit) begin
            rom_data_o = 64'h0;
        end
        ram_ready_o = ram_en_i && ph_q;
    end

    // wait counter, half-rate sink, capture of written words
    always @(posedge clk_i) begin
        ph_q <= ~ph_q;
        if (!nrst_i) begin
            wait_q <= 2'h0;
            last_q <= 64'h0;
            ph_q <= 1'b0;
        end else if (hit) begin
            wait_q <= 2'h0;
            last_q <= rom_data_o;
        end else if (rom_req_i) begin
            wait_q <= wait_q + 2'h1;
        end
        if (ram_valid_i && ram_ready_o) begin
            if (ram_addr_i !== rbl_pkg::RAM_BASE + 64'(ram.size()) * 64'h8) begin
                ram_bad <= 1'b1;
            end
            ram.push_back(ram_data_i);
        end
    end
endmodule

// [testbench/testbench.sv]
// self-checking bench for the rom boot image loader
`timescale 1ns/1ps
module testbench;
    typedef struct {
        logic [7:0] ord;
        logic val, cpy, aud, stall;
        rbl_pkg::rbl_abort_t step;
        logic [63:0] sa;
        int nw;
    } rbl_row_t;
    localparam logic [63:0] LBLX = 64'h6c61_6265_6c00_0000;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0, nrst_i = 1'b0, start_i = 1'b0, ack_i = 1'b0;
    logic [7:0] ordinal_i = 8'h0;
    logic validate_i = 1'b0, copy_i = 1'b0, audit_i = 1'b0;
    logic [rbl_pkg::NREG-1:0][63:0] region_lo_i, region_hi_i;
    logic rom_req_o, rom_ack_i, rom_err_i, ram_valid_o, ram_ready_i;
    logic [63:0] rom_addr_o, rom_data_i, ram_addr_o, ram_data_o;
    logic evt_valid_o, abort_o, ready_o;
    rbl_pkg::rbl_evt_t evt_code_o;
    rbl_pkg::rbl_abort_t abort_step_o;
    logic [63:0] loader_label_word_o, start_addr_o;
    logic [1:0] rom_lat = 2'h0;
    logic ram_en = 1'b1;
    int err_count = 0, n_compared = 0;
    rbl_pkg::rbl_evt_t evq [$];
    // ordinals 0,1 in region 0, 2 in region 1, 3 in region 3
    rbl_row_t rows [7] = '{
        '{8'h0, 1, 1, 1, 0, rbl_pkg::AB_NONE, 64'h10030, 4},
        '{8'h1, 1, 1, 1, 1, rbl_pkg::AB_NONE, 64'h12030, 38},
        '{8'h2, 0, 1, 1, 0, rbl_pkg::AB_NONE, 64'h40030, 8},
        '{8'h2, 1, 1, 1, 0, rbl_pkg::AB_SUM, 64'h40030, 0},
        '{8'h3, 0, 0, 1, 0, rbl_pkg::AB_PAGE, 64'h90030, 0},
        '{8'h4, 0, 0, 1, 0, rbl_pkg::AB_NOT_FOUND, 64'h90030, 0},
        '{8'h1, 1, 0, 0, 0, rbl_pkg::AB_NONE, 64'h12030, 0}
    };

    rbl_loader u_rbl_loader (.clk_i(clk_i), .nrst_i(nrst_i),
        .start_i(start_i), .ordinal_i(ordinal_i), .validate_i(validate_i),
        .copy_i(copy_i), .audit_i(audit_i), .region_lo_i(region_lo_i),
        .region_hi_i(region_hi_i), .rom_req_o(rom_req_o),
        .rom_addr_o(rom_addr_o), .rom_ack_i(rom_ack_i),
        .rom_err_i(rom_err_i), .rom_data_i(rom_data_i),
        .ram_valid_o(ram_valid_o), .ram_ready_i(ram_ready_i),
        .ram_addr_o(ram_addr_o), .ram_data_o(ram_data_o),
        .evt_valid_o(evt_valid_o), .evt_code_o(evt_code_o),
        .loader_label_word_o(loader_label_word_o), .abort_o(abort_o),
        .abort_step_o(abort_step_o), .ready_o(ready_o),
        .start_addr_o(start_addr_o), .ack_i(ack_i));
    rbl_mem_model u_rbl_mem_model (.clk_i(clk_i), .nrst_i(nrst_i),
        .rom_req_i(rom_req_o), .rom_addr_i(rom_addr_o),
        .rom_ack_o(rom_ack_i), .rom_err_o(rom_err_i),
        .rom_data_o(rom_data_i), .ram_valid_i(ram_valid_o),
        .ram_ready_o(ram_ready_i), .ram_addr_i(ram_addr_o),
        .ram_data_i(ram_data_o), .rom_lat_i(rom_lat), .ram_en_i(ram_en));

    // 250 MHz clock and event capture
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (evt_valid_o === 1'b1) begin
            evq.push_back(evt_code_o);
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [63:0] exp,
                       input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // header at b, image after it; flaw 1 marker, 2 complement,
    // 3 header sum, 4 image sum
    task automatic mk(input logic [63:0] b, input logic [63:0] len,
                      input int flaw);
        logic [63:0] w [6];
        logic [63:0] s;
        logic [63:0] v;
        s = 64'h0;
        for (int i = 0; i < int'(len >> 3); i++) begin
            v = b ^ (64'(i) * 64'h101);
            u_rbl_mem_model.rom[b + 64'h30 + 64'(i) * 64'h8] = v;
            s = s + v;
        end
        w[0] = {~32'h80, 32'h80};
        if (flaw == 1) w[0] = {~32'h81, 32'h81};
        if (flaw == 2) w[0] = {32'h0, 32'h80};
        w[1] = (flaw == 4) ? ~s : s;
        w[2] = 64'h30;
        w[3] = len;
        w[4] = b ^ LBLX;
        w[5] = w[0] + w[1] + w[2] + w[3] + w[4] + 64'(flaw == 3);
        for (int i = 0; i < 6; i++) begin
            u_rbl_mem_model.rom[b + 64'(i) * 64'h8] = w[i];
        end
    endtask

    task automatic run(input rbl_row_t r, input int k);
        rbl_pkg::rbl_evt_t ex [$];
        int n;
        int st;
        ex = {};
        evq = {};
        u_rbl_mem_model.ram.delete();
        n = (r.step == rbl_pkg::AB_NOT_FOUND) ? 4 : int'(r.ord) + 1;
        repeat (n) ex.push_back(rbl_pkg::EVT_BOOT_TYPE);
        if (r.step != rbl_pkg::AB_NOT_FOUND && r.step != rbl_pkg::AB_PAGE)
            ex.push_back(rbl_pkg::EVT_PAGES_REACHABLE);
        if (r.step == rbl_pkg::AB_NONE && r.val)
            ex.push_back(rbl_pkg::EVT_PAYLOAD_VERIFIED);
        if (r.step == rbl_pkg::AB_NONE && r.cpy) begin
            ex.push_back(rbl_pkg::EVT_LOAD_BEGINS);
            ex.push_back(rbl_pkg::EVT_LOAD_DONE);
        end
        if (!r.aud) ex = {};
        @(posedge clk_i);
        ordinal_i <= r.ord;
        validate_i <= r.val;
        copy_i <= r.cpy;
        audit_i <= r.aud;
        rom_lat <= 2'(k);
        ram_en <= !r.stall;
        start_i <= 1'b1;
        @(posedge clk_i);
        ordinal_i <= 8'hff; // a busy loader ignores a new ordinal
        repeat (2) @(posedge clk_i);
        start_i <= 1'b0;
        n = 0;
        st = 0;
        while (ready_o !== 1'b1 && abort_o !== 1'b1 && n < 30000) begin
            @(posedge clk_i);
            if (st == 300) ram_en <= 1'b1;
            #1;
            n++;
            if (ram_valid_o === 1'b1) st++;
        end
        chk("finished", 1, n < 30000);
        chk("abort", r.step != rbl_pkg::AB_NONE, abort_o);
        chk("abort_step", r.step, abort_step_o);
        chk("label", (r.sa - 64'h30) ^ LBLX, loader_label_word_o);
        if (r.step == rbl_pkg::AB_NONE)
            chk("start_addr", r.sa, start_addr_o);
        repeat (3) @(posedge clk_i);
        #1;
        chk("ready", r.step == rbl_pkg::AB_NONE, ready_o);
        chk("abort held", r.step != rbl_pkg::AB_NONE, abort_o);
        chk("rom idle", 0, rom_req_o);
        if (ready_o === 1'b1) begin
            @(posedge clk_i) ack_i <= 1'b1;
            @(posedge clk_i) ack_i <= 1'b0;
            #1;
            chk("ready after ack", 0, ready_o);
        end
        chk("events", ex.size(), evq.size());
        for (int i = 0; i < ex.size() && i < evq.size(); i++)
            chk("event code", ex[i], evq[i]);
        chk("ram words", r.nw, u_rbl_mem_model.ram.size());
        for (int i = 0; i < r.nw && i < u_rbl_mem_model.ram.size(); i++)
            chk("ram data", u_rbl_mem_model.rom[r.sa + 64'(i) * 64'h8],
                u_rbl_mem_model.ram[i]);
        chk("ram order", 0, u_rbl_mem_model.ram_bad);
        $display("test %0d done", k);
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        region_lo_i = {64'h90000, 64'h80000, 64'h40000, 64'h10000};
        region_hi_i = {64'h94000, 64'h82000, 64'h42000, 64'h1a000};
        u_rbl_mem_model.bad_lo = 64'h92000;
        u_rbl_mem_model.bad_hi = 64'h93000;
        mk(64'h10000, 64'h20, 0);
        mk(64'h12000, 64'h130, 0);
        mk(64'h14000, 64'h20, 1);
        mk(64'h16000, 64'h20, 2);
        mk(64'h18000, 64'h20, 3);
        mk(64'h30000, 64'h20, 0);
        mk(64'h40000, 64'h40, 4);
        mk(64'h90000, 64'h2000, 0);
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int k = 0; k < 7; k++) run(rows[k], k);
        // reset in mid-scan leaves every output quiet
        @(posedge clk_i);
        ordinal_i <= 8'h1;
        start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("reset req", 0, rom_req_o);
        chk("reset outs", 0, {ready_o, abort_o, evt_valid_o, ram_valid_o});
        chk("reset step", 0, abort_step_o);
        @(posedge clk_i) nrst_i <= 1'b1;
        run(rows[1], 7);
        results();
    end

    // watchdog well beyond the expected run length
    initial begin
        #100000;
        err_count++;
        results();
    end
endmodule
